// >>> design/ccp_control_port.sv
// serial control port: pin sampling, control registers, pcm slot logic
`default_nettype none
// Contract
// R1: static low, address neg: normal, switches active
// R2: static high, address neg: powerdown, pcm floats
// R3: eight control bits per slot with pcm
// R4: address neg loads primary, clears auxiliary
// R5: address ground loads primary, auxiliary kept
// R6: address pos loads auxiliary, pcm inhibited
// R7: auxiliary drives switches and test modes
// R8: controller gives one frame pulse per frame
// R9: frame enable low one slot per frame
// R10: dual mode uses two slots per frame
// R11: first serial bit is bit seven
// R12: power-up holds powerdown, writes ignored
// R13: auxiliary bits 7:6 choose test target
// R14: primary bits set transmit and receive gain
// R15: primary bits 7:6 select function mode
// R16: digital loopback returns pcm input word
// R17: digital loopback forces decoder input zero
// R18: digital loopback discards encoder result
// R19: analog loopback grounds analog output buffer
// R20: analog loopback feeds receive into transmit
// R21: loopback keeps pcm pins as source/sink
// R22: auxiliary bits 0-5 drive switch outputs
// R23: auxiliary bits 7:6 decode test modes
// R24: sample on falling, launch on rising edges
// R25: power-up clears auxiliary, primary = c0
// R26: register updates only after eight bits
module ccp_control_port
    import ccp_pkg::*;
#(
    parameter int NUM_SWITCH = 6
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        bit_clock_in,
    input  wire logic        frame_enable_n,
    input  wire logic        control_serial_in,
    input  wire logic        pcm_serial_in,
    input  wire logic [1:0]  control_address_select,
    input  wire logic        static_control_mode,
    input  wire logic [7:0]  encoder_word,
    output logic             pcm_serial_out,
    output logic             pcm_out_en_n,
    output logic [7:0]       decoder_word,
    output logic [2:0]       tx_gain_db,
    output logic [2:0]       rx_atten_db,
    output logic             powerdown,
    output logic             digital_loopback,
    output logic             analog_loopback,
    output logic             analog_output_grounded,
    output logic             analog_input_detached,
    output logic             rx_to_tx_feedback,
    output logic [NUM_SWITCH-1:0] switch_outputs,
    output logic [1:0]       test_mode
);
    if (NUM_SWITCH != 4 && NUM_SWITCH != 6) begin : g_bad_switch_count
        $error("ccp_control_port: NUM_SWITCH must be 4 or 6");
    end

    // -------------------------------------------------------------
    // pin sampling: three flops, accept when stages two and three agree
    // -------------------------------------------------------------
    localparam int NPIN = 7;
    localparam logic [NPIN-1:0] PIN_IDLE = 7'h02; // idle pins: frame high, the rest low
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_r;
    logic [NPIN-1:0] s2_r;
    logic [NPIN-1:0] s3_r;
    logic [NPIN-1:0] pin_f_r;
    assign pin_raw = {static_control_mode, control_address_select, pcm_serial_in,
                      control_serial_in, frame_enable_n, bit_clock_in};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_r[gi]    <= PIN_IDLE[gi];
                    s2_r[gi]    <= PIN_IDLE[gi];
                    s3_r[gi]    <= PIN_IDLE[gi];
                    pin_f_r[gi] <= PIN_IDLE[gi];
                end else begin
                    s1_r[gi] <= pin_raw[gi];
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                    if (s2_r[gi] == s3_r[gi]) begin
                        pin_f_r[gi] <= s3_r[gi];
                    end
                end
            end
        end
    endgenerate
    logic       bclk_f;
    logic       frame_n_f;
    logic       ctrl_f;
    logic       pcm_f;
    logic [1:0] addr_f;
    logic       static_f;
    logic       bclk_d_r;
    logic       fall;
    logic       rise;
    logic       in_slot;
    assign bclk_f    = pin_f_r[0];
    assign frame_n_f = pin_f_r[1];
    assign ctrl_f    = pin_f_r[2];
    assign pcm_f     = pin_f_r[3];
    assign addr_f    = pin_f_r[5:4];
    assign static_f  = pin_f_r[6];
    assign fall      = bclk_d_r && !bclk_f;
    assign rise      = !bclk_d_r && bclk_f;
    assign in_slot   = !frame_n_f;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bclk_d_r <= PIN_IDLE[0];
        end else begin
            bclk_d_r <= bclk_f;
        end
    end

    // -------------------------------------------------------------
    // power-up hold counted in bit clock cycles
    // -------------------------------------------------------------
    logic [4:0] pu_cnt_r;
    logic       pu_done;
    assign pu_done = (pu_cnt_r == 5'(PU_BIT_CYCLES));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pu_cnt_r <= '0;
        end else if (fall && !pu_done) begin
            pu_cnt_r <= pu_cnt_r + 5'h1;
        end
    end

    // -------------------------------------------------------------
    // serial input shifting, msb first on falling edges
    // -------------------------------------------------------------
    logic [3:0] bit_cnt_r;
    logic [7:0] ctrl_sh_r;
    logic [7:0] pcm_sh_r;
    logic       word_done;
    logic [7:0] ctrl_word;
    logic [7:0] pcm_word;
    assign word_done = fall && in_slot && (bit_cnt_r == 4'(SLOT_BITS - 1)); // [R26]
    assign ctrl_word = {ctrl_sh_r[6:0], ctrl_f}; // [R11]
    assign pcm_word  = {pcm_sh_r[6:0], pcm_f};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bit_cnt_r <= '0;
            ctrl_sh_r <= '0;
            pcm_sh_r  <= '0;
        end else if (!in_slot) begin
            bit_cnt_r <= '0;
        end else if (fall && bit_cnt_r < 4'(SLOT_BITS)) begin // [R3] [R24]
            bit_cnt_r <= bit_cnt_r + 4'h1;
            ctrl_sh_r <= ctrl_word; // [R11]
            pcm_sh_r  <= pcm_word;
        end
    end

    // -------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------
    logic [7:0] primary_r;
    logic [7:0] aux_r;
    logic       static_apply;
    assign static_apply = pu_done && static_f && (addr_f == ADDR_NEG);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            primary_r <= PRI_RESET; // [R25]
            aux_r     <= AUX_RESET;
        end else if (!pu_done) begin
            primary_r <= PRI_RESET; // [R12] [R25]
            aux_r     <= AUX_RESET;
        end else if (static_apply) begin
            primary_r <= ctrl_f ? PRI_RESET : PRI_STATIC_ON; // [R1] [R2]
            aux_r     <= ctrl_f ? AUX_RESET : AUX_STATIC_ON;
        end else if (word_done) begin
            case (addr_f)
                ADDR_NEG: begin
                    primary_r <= ctrl_word; // [R4]
                    aux_r     <= AUX_RESET;
                end
                ADDR_GND: begin
                    primary_r <= ctrl_word; // [R5]
                end
                ADDR_POS: begin
                    aux_r <= ctrl_word; // [R6]
                end
                default: ;
            endcase
        end
    end

    // -------------------------------------------------------------
    // pcm receive: words buffered for loopback, decoder word
    // -------------------------------------------------------------
    ccp_stream_if #(.WIDTH(WORD_W)) rx_in ();
    ccp_stream_if #(.WIDTH(WORD_W)) rx_out ();
    ccp_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk  (clk),
        .nrst (nrst),
        .wr   (rx_in.sink),
        .rd   (rx_out.src)
    );
    logic [7:0] rx_word_r;
    logic       rx_pend_r;
    logic       pcm_ok;
    logic       dig_loop;
    assign pcm_ok   = (addr_f != ADDR_POS) && pu_done; // [R6]
    assign dig_loop = (primary_r[FUNC_LSB +: 2] == FUNC_DIG_LOOP);
    assign rx_in.valid = rx_pend_r;
    assign rx_in.data  = rx_word_r;
    // a word waits here while the buffer is full
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_pend_r <= 1'b0;
            rx_word_r <= '0;
        end else if (word_done && pcm_ok && (!rx_pend_r || rx_in.ready)) begin
            rx_pend_r <= 1'b1; // [R16] [R21]
            rx_word_r <= pcm_word;
        end else if (rx_in.ready) begin
            rx_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            decoder_word <= '0;
        end else if (word_done && pcm_ok) begin
            decoder_word <= dig_loop ? 8'h00 : pcm_word; // [R17]
        end
    end

    // -------------------------------------------------------------
    // pcm transmit: launched on rising edges within the slot
    // -------------------------------------------------------------
    logic [7:0] tx_sh_r;
    logic       tx_started_r;
    logic       tx_first;
    assign tx_first     = rise && in_slot && !tx_started_r;
    assign rx_out.ready = tx_first && pcm_ok;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_sh_r      <= '0;
            tx_started_r <= 1'b0;
        end else if (!in_slot) begin
            tx_started_r <= 1'b0;
        end else if (tx_first) begin // [R24]
            tx_started_r <= 1'b1;
            if (dig_loop) begin
                tx_sh_r <= rx_out.valid ? rx_out.data : 8'h00; // [R16] [R18]
            end else begin
                tx_sh_r <= encoder_word;
            end
        end else if (rise) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pcm_serial_out <= 1'b0;
            pcm_out_en_n   <= 1'b1;
        end else begin
            pcm_serial_out <= tx_sh_r[7];
            // judged from the register itself so the float starts with powerdown
            pcm_out_en_n   <= !(in_slot && tx_started_r && pcm_ok
                                && (primary_r[FUNC_LSB +: 2] != FUNC_PWRDOWN)); // [R2]
        end
    end

    // -------------------------------------------------------------
    // decoded control outputs
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_gain_db             <= '0;
            rx_atten_db            <= '0;
            powerdown              <= 1'b1;
            digital_loopback       <= 1'b0;
            analog_loopback        <= 1'b0;
            analog_output_grounded <= 1'b1;
            analog_input_detached  <= 1'b0;
            rx_to_tx_feedback      <= 1'b0;
            switch_outputs         <= '0;
            test_mode              <= TEST_NONE;
        end else begin
            tx_gain_db       <= primary_r[TXG_LSB +: 3]; // [R14]
            rx_atten_db      <= primary_r[RXG_LSB +: 3];
            powerdown        <= (primary_r[FUNC_LSB +: 2] == FUNC_PWRDOWN); // [R15]
            digital_loopback <= dig_loop;
            analog_loopback  <= (primary_r[FUNC_LSB +: 2] == FUNC_ANA_LOOP);
            analog_output_grounded <= primary_r[FUNC_LSB + 1]; // [R2] [R19]
            analog_input_detached  <= (primary_r[FUNC_LSB +: 2] == FUNC_ANA_LOOP); // [R20]
            rx_to_tx_feedback      <= (primary_r[FUNC_LSB +: 2] == FUNC_ANA_LOOP);
            switch_outputs   <= aux_r[SW_LSB +: NUM_SWITCH]; // [R7] [R22]
            test_mode        <= aux_r[TEST_LSB +: 2]; // [R13] [R23]
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    a_pu_hold: assert property (!pu_done |=> primary_r == PRI_RESET && aux_r == AUX_RESET) // [R12]
        else $error("registers changed during power-up hold");
    a_neg_load: assert property (pu_done && !static_apply && word_done && addr_f == ADDR_NEG
                                 |=> primary_r == $past(ctrl_word) && aux_r == 8'h00) // [R4]
        else $error("address neg load wrong");
    a_gnd_load: assert property (pu_done && !static_apply && word_done && addr_f == ADDR_GND
                                 |=> $stable(aux_r) && primary_r == $past(ctrl_word)) // [R5]
        else $error("address ground load wrong");
    a_pos_load: assert property (pu_done && word_done && addr_f == ADDR_POS
                                 |=> $stable(primary_r) && aux_r == $past(ctrl_word)) // [R6]
        else $error("address pos load wrong");
    a_pos_inhibit: assert property (addr_f == ADDR_POS |=> pcm_out_en_n) // [R6]
        else $error("pcm driven while address pos");
    a_no_early_update: assert property ($changed(aux_r) && $past(pu_done)
                                        |-> $past(word_done || static_apply)) // [R26]
        else $error("auxiliary changed before full word");
    a_static_low: assert property (static_apply && !ctrl_f |=> ##1 tx_gain_db == 3'h0 // [R1]
                                   && !powerdown && test_mode == TEST_NONE)
        else $error("static normal mode wrong");
    a_pd_float: assert property (powerdown |-> pcm_out_en_n) // [R2]
        else $error("pcm driven in powerdown");
    a_gain_map: assert property (1'b1 |=> tx_gain_db == $past(primary_r[2:0])
                                 && rx_atten_db == $past(primary_r[5:3])) // [R14]
        else $error("gain decode wrong");
    a_dig_zero: assert property (dig_loop && word_done && pcm_ok |=> decoder_word == 8'h00) // [R17]
        else $error("decoder not zero in digital loopback");
    c_primary_load: cover property (pu_done && word_done && addr_f == ADDR_GND);
    c_aux_load:     cover property (pu_done && word_done && addr_f == ADDR_POS);
    c_dig_loop_tx:  cover property (tx_first && dig_loop && rx_out.valid);
    c_static_pd:    cover property (static_apply && ctrl_f);
endmodule
`default_nettype wire

// >>> design/ccp_pkg.sv
// constants for the codec serial control port
`default_nettype none
package ccp_pkg;
    // -------------------------------------------------------------
    // address pin levels as presented by the level translator
    // -------------------------------------------------------------
    localparam logic [1:0] ADDR_NEG = 2'h0;
    localparam logic [1:0] ADDR_GND = 2'h1;
    localparam logic [1:0] ADDR_POS = 2'h2;

    // -------------------------------------------------------------
    // control word layout
    // -------------------------------------------------------------
    localparam int TXG_LSB  = 0;
    localparam int RXG_LSB  = 3;
    localparam int FUNC_LSB = 6;
    localparam int SW_LSB   = 0;
    localparam int TEST_LSB = 6;
    localparam int WORD_W   = 8;

    // -------------------------------------------------------------
    // function and test mode codes
    // -------------------------------------------------------------
    localparam logic [1:0] FUNC_NORMAL   = 2'h0;
    localparam logic [1:0] FUNC_DIG_LOOP = 2'h1;
    localparam logic [1:0] FUNC_ANA_LOOP = 2'h2;
    localparam logic [1:0] FUNC_PWRDOWN  = 2'h3;
    localparam logic [1:0] TEST_NONE     = 2'h0;
    localparam logic [1:0] TEST_TX_FILT  = 2'h1;
    localparam logic [1:0] TEST_RX_FILT  = 2'h2;
    localparam logic [1:0] TEST_CODEC    = 2'h3;

    // -------------------------------------------------------------
    // reset values and static mode words
    // -------------------------------------------------------------
    localparam logic [7:0] PRI_RESET     = 8'hc0;
    localparam logic [7:0] AUX_RESET     = 8'h00;
    localparam logic [7:0] PRI_STATIC_ON = 8'h00;
    localparam logic [7:0] AUX_STATIC_ON = 8'h3f;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int PU_BIT_CYCLES = 25;
    localparam int SLOT_BITS     = 8;
    localparam int FIFO_DEPTH    = 4;
endpackage
`default_nettype wire

// >>> design/ccp_stream_if.sv
// valid/ready word carrier between the port logic and its buffer
`default_nettype none
interface ccp_stream_if #(parameter int WIDTH = 8);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> design/ccp_fifo.sv
// small word fifo with registered read data
`default_nettype none
module ccp_fifo
    import ccp_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic  clk,
    input  wire logic  nrst,
    ccp_stream_if.sink wr,
    ccp_stream_if.src  rd
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_shape
        $error("ccp_fifo: depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      cnt_r;
    logic             out_v_r;
    logic [WIDTH-1:0] out_d_r;
    logic             push;
    logic             load;

    // storage plus one output stage; ready reflects the storage only
    assign wr.ready = (cnt_r < (AW+1)'(DEPTH));
    assign push     = wr.valid && wr.ready;
    assign load     = (cnt_r != '0) && (!out_v_r || rd.ready);
    assign rd.valid = out_v_r;
    assign rd.data  = out_d_r;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            out_v_r <= 1'b0;
            out_d_r <= '0;
        end else if (load) begin
            out_v_r <= 1'b1;
            out_d_r <= mem[rd_ptr_r];
        end else if (rd.ready) begin
            out_v_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> design/ccp_fifo_dummy_guard.sv
// holds no logic; the word buffer lives in ccp_fifo.sv

// >>> verification/ccp_ctrl_model.sv
// serial controller model: bit clock, frame, address, control and pcm pins
`default_nettype none
module ccp_ctrl_model
    import ccp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       pcm_serial_out,
    input  wire logic       pcm_out_en_n,
    output var  logic       bit_clock_in,
    output var  logic       frame_enable_n,
    output var  logic       control_serial_in,
    output var  logic       pcm_serial_in,
    output var  logic [1:0] control_address_select,
    output var  logic [7:0] rx_word,
    output var  logic       rx_driven
);
    timeunit 1ns;
    timeprecision 1ps;
    int div_cnt = 0;
    initial begin
        bit_clock_in = 1'b0;
        frame_enable_n = 1'b1;
        control_serial_in = 1'b0;
        pcm_serial_in = 1'b1;
        control_address_select = ADDR_NEG;
        rx_word = 8'h00;
        rx_driven = 1'b0;
    end
    // free-running bit clock, 20 clk per bit
    always @(negedge clk) begin
        div_cnt <= (div_cnt == 9) ? 0 : div_cnt + 1;
        if (div_cnt == 9) begin
            bit_clock_in <= ~bit_clock_in;
        end
    end
    // one slot of nbits, data launched on rising, output sampled on falling
    task automatic send(input logic [1:0] addr, input logic [7:0] cw, input logic [7:0] pw,
                        input int nbits);
        int i;
        @(negedge bit_clock_in);
        // frame falls two clocks after the bit clock, never together with it
        repeat (2) @(negedge clk);
        frame_enable_n = 1'b0;
        control_address_select = addr;
        rx_driven = 1'b0;
        for (i = 7; i > 7 - nbits; i--) begin
            @(posedge bit_clock_in);
            control_serial_in = cw[i];
            pcm_serial_in = pw[i];
            @(negedge bit_clock_in);
            rx_word[i] = pcm_out_en_n ? 1'b1 : pcm_serial_out; // floating line reads high
            if (pcm_out_en_n === 1'b0) begin
                rx_driven = 1'b1;
            end
        end
        repeat (2) @(negedge clk);
        frame_enable_n = 1'b1;
        control_serial_in = ~control_serial_in;
        pcm_serial_in = ~pcm_serial_in;
        repeat (8) @(negedge clk);
    endtask
    task automatic set_level(input logic lvl);
        @(negedge clk);
        control_address_select = ADDR_NEG;
        control_serial_in = lvl;
        repeat (10) @(negedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verification/ccp_control_port_bench.sv
// self-checking bench for the codec serial control port
`default_nettype none
module ccp_control_port_bench
    import ccp_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       nrst;
    logic       static_control_mode;
    logic [7:0] encoder_word;
    logic       bclk, fen_n, csi, psi, pso, poe_n, pd, dl, al, ag, ad, fb, rx_driven;
    logic [1:0] addr, tm;
    logic [2:0] txg, rxg;
    logic [5:0] sw;
    logic [7:0] dec_w, rx_word, mode_v, gain_v, sw_v;
    int         fail_count = 0;
    int         num_checks = 0;
    assign mode_v = {pd, dl, al, ag, ad, fb, tm};
    assign gain_v = {2'h0, rxg, txg};
    assign sw_v = {2'h0, sw};
    ccp_control_port DUT (.clk(clk), .nrst(nrst), .bit_clock_in(bclk), .frame_enable_n(fen_n),
        .control_serial_in(csi), .pcm_serial_in(psi), .control_address_select(addr),
        .static_control_mode(static_control_mode), .encoder_word(encoder_word),
        .pcm_serial_out(pso), .pcm_out_en_n(poe_n), .decoder_word(dec_w), .tx_gain_db(txg),
        .rx_atten_db(rxg), .powerdown(pd), .digital_loopback(dl), .analog_loopback(al),
        .analog_output_grounded(ag), .analog_input_detached(ad), .rx_to_tx_feedback(fb),
        .switch_outputs(sw), .test_mode(tm));
    ccp_ctrl_model ctl (.clk(clk), .pcm_serial_out(pso), .pcm_out_en_n(poe_n),
        .bit_clock_in(bclk), .frame_enable_n(fen_n), .control_serial_in(csi),
        .pcm_serial_in(psi), .control_address_select(addr), .rx_word(rx_word),
        .rx_driven(rx_driven));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [7:0] exp_mode(input logic [1:0] f, input logic [1:0] t);
        return {f == 2'h3, f == 2'h1, f == 2'h2, f[1], f == 2'h2, f == 2'h2, t};
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        repeat (20) @(negedge clk);
        check(mode_v, 8'h90);
        check({gain_v[5:0], 1'b0, poe_n}, 8'h01);
        nrst = 1'b1;
        ctl.send(ADDR_NEG, 8'h00, 8'h00, 8);
        check(mode_v, 8'h90);
        check(sw_v, 8'h00);
        repeat (400) @(negedge clk);
    endtask
    task automatic t_primary();
        encoder_word = 8'ha5;
        ctl.send(ADDR_GND, 8'h1d, 8'h96, 8);
        check(gain_v, 8'h1d);
        check(mode_v, exp_mode(FUNC_NORMAL, TEST_NONE));
        ctl.send(ADDR_GND, 8'h1d, 8'h96, 8);
        check(rx_word, 8'ha5);
        check(dec_w, 8'h96);
        check({7'h00, rx_driven}, 8'h01);
    endtask
    task automatic t_aux_then_gnd();
        ctl.send(ADDR_POS, 8'h6a, 8'h55, 8);
        check(sw_v, 8'h2a);
        check(mode_v, exp_mode(FUNC_NORMAL, TEST_TX_FILT));
        check(gain_v, 8'h1d);
        check({7'h00, rx_driven}, 8'h00);
        check(dec_w, 8'h96);
        ctl.send(ADDR_GND, 8'h07, 8'h11, 8);
        check(sw_v, 8'h2a);
        check(gain_v, 8'h07);
    endtask
    task automatic t_func_codes();
        int f;
        for (f = 0; f < 4; f++) begin
            ctl.send(ADDR_NEG, {2'(f), 6'h00}, 8'h00, 8);
            check(mode_v, exp_mode(2'(f), TEST_NONE));
            check(sw_v, 8'h00);
        end
    endtask
    task automatic t_test_codes();
        int t;
        for (t = 0; t < 4; t++) begin
            ctl.send(ADDR_POS, {2'(t), 6'h3f}, 8'h00, 8);
            check(mode_v, exp_mode(FUNC_PWRDOWN, 2'(t)));
            check(sw_v, 8'h3f);
        end
    endtask
    task automatic t_dig_loop();
        encoder_word = 8'hff;
        ctl.send(ADDR_NEG, 8'h40, 8'h3c, 8);
        ctl.send(ADDR_NEG, 8'h40, 8'h3c, 8);
        ctl.send(ADDR_NEG, 8'h40, 8'h00, 8);
        check(rx_word, 8'h3c);
        check(dec_w, 8'h00);
    endtask
    task automatic t_short_word();
        ctl.send(ADDR_GND, 8'hff, 8'h00, 4);
        check(mode_v, exp_mode(FUNC_DIG_LOOP, TEST_NONE));
        check(gain_v, 8'h00);
    endtask
    task automatic t_static();
        static_control_mode = 1'b1;
        ctl.set_level(1'b0);
        check(mode_v, exp_mode(FUNC_NORMAL, TEST_NONE));
        check({gain_v[5:0], sw_v[1:0]}, 8'h03);
        ctl.set_level(1'b1);
        check(mode_v, exp_mode(FUNC_PWRDOWN, TEST_NONE));
        check({7'h00, poe_n}, 8'h01);
        @(negedge clk);
        static_control_mode = 1'b0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        nrst = 1'b0;
        static_control_mode = 1'b0;
        encoder_word = 8'h00;
        t_reset();
        t_primary();
        t_aux_then_gnd();
        t_func_codes();
        t_test_codes();
        t_dig_loop();
        t_short_word();
        t_static();
        stop_test();
    end
endmodule
`default_nettype wire
